// ### rtl/vli_params.svh
`ifndef VLI_PARAMS_SVH
`define VLI_PARAMS_SVH

// register byte offsets
`define VLI_OFS_CTRL 8'h00
`define VLI_OFS_STATUS 8'h04
`define VLI_OFS_VERSION 8'h08

// control register fields
`define VLI_CTRL_RESTART 0
`define VLI_CTRL_SKIP 1
`define VLI_CTRL_ALLON 2
`define VLI_CTRL_RST 32'h0000_0000

// status register fields
`define VLI_STAT_LED_LSB 0
`define VLI_STAT_PHASE_LSB 4
`define VLI_STAT_DONE 8

// led vector bit positions
`define VLI_LED_USB 0
`define VLI_LED_SDI 1
`define VLI_LED_PWR 2
`define VLI_LED_DATA 3

// timing, in milliseconds, and the clock rate in kHz
`define VLI_CLK_KHZ 250000
`define VLI_STEP_MS 250
`define VLI_DIGIT_MS 500
`define VLI_GAP_MS 250
`define VLI_PAUSE_MS 1000
`define VLI_FLASH_MS 125
`define VLI_HOLD_MS 50

`endif

// ### rtl/vli_pkg.sv
package vli_pkg;
   // sequencer phases
   typedef enum logic [3:0] {
      S_START = 4'h0,
      S_TEST = 4'h1,
      S_PAUSE1 = 4'h2,
      S_MCU_MAJ = 4'h3,
      S_GAP1 = 4'h4,
      S_MCU_MIN = 4'h5,
      S_PAUSE2 = 4'h6,
      S_FPGA_MAJ = 4'h7,
      S_GAP2 = 4'h8,
      S_FPGA_MIN = 4'h9,
      S_PAUSE3 = 4'ha,
      S_NORMAL = 4'hb
   } vli_state_t;
   typedef logic [3:0] vli_led_t;
endpackage

// ### rtl/vli_tmr_if.sv
`timescale 1ns/1ps
`default_nettype none
// link between the sequencer and its interval timer
interface vli_tmr_if #(parameter int W = 32);
   logic load; // start a new interval
   logic [W-1:0] cycles; // interval length, at least one
   logic done; // last cycle of the interval
   modport ctl (output load, output cycles, input done);
   modport tmr (input load, input cycles, output done);
endinterface
`default_nettype wire

// ### rtl/vli_step_timer.sv
`timescale 1ns/1ps
`default_nettype none
module vli_step_timer #(
   parameter int W = 32
) (
   input wire logic pclk,
   input wire logic presetn,
   vli_tmr_if.tmr t
);
   logic [W-1:0] cnt_q, cnt_d; // cycles left minus one
   logic run_q, run_d; // interval in progress

   // an interval of n cycles: done is high in its n-th cycle
   always_comb begin
      cnt_d = cnt_q;
      run_d = run_q;
      if (t.load) begin
         cnt_d = t.cycles - W'(1);
         run_d = 1'b1;
      end else if (run_q) begin
         if (cnt_q == '0) begin
            run_d = 1'b0;
         end else begin
            cnt_d = cnt_q - W'(1);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= '0;
         run_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         run_q <= run_d;
      end
   end

   assign t.done = run_q && (cnt_q == '0);
endmodule // vli_step_timer
`default_nettype wire

// ### rtl/vli_top.sv
// Functional notes
// [R1] lamp test walks all four leds in order
// [R2] digit one to four lights one led
// [R3] pause, then controller major and minor digit
// [R4] pause, then logic chip major and minor
// [R5] dark gap between major and minor digit
// [R6] final pause, then power led steady on
// [R7] usb led only while a drive is present
// [R8] video led follows valid video detect
// [R9] data led lit on remote data reception
// [R10] usb led flashes loading, steady when done
// [R11] all durations are clock cycle parameters
//
// The register addresses and the APB slave port are this design's own decisions.
`include "vli_params.svh"
`timescale 1ns/1ps
`default_nettype none
module vli_top
   import vli_pkg::*;
#(
   parameter int STEP_CYC = `VLI_STEP_MS * `VLI_CLK_KHZ, // [R11]
   parameter int DIGIT_CYC = `VLI_DIGIT_MS * `VLI_CLK_KHZ,
   parameter int GAP_CYC = `VLI_GAP_MS * `VLI_CLK_KHZ,
   parameter int PAUSE_CYC = `VLI_PAUSE_MS * `VLI_CLK_KHZ,
   parameter int FLASH_CYC = `VLI_FLASH_MS * `VLI_CLK_KHZ,
   parameter int HOLD_CYC = `VLI_HOLD_MS * `VLI_CLK_KHZ
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [2:0] mcu_major,
   input wire logic [2:0] mcu_minor,
   input wire logic [2:0] fpga_major,
   input wire logic [2:0] fpga_minor,
   input wire logic usb_present,
   input wire logic usb_loading,
   input wire logic usb_load_done,
   input wire logic sdi_valid,
   input wire logic remote_rx_strobe,
   output logic led_usb,
   output logic led_sdi,
   output logic led_power,
   output logic led_data
);
   // digit to led, out-of-range values clamp to the nearest end
   function automatic vli_led_t digit_led(input logic [2:0] d);
      case (d)
         3'h0, 3'h1: digit_led = 4'h1; // [R2]
         3'h2: digit_led = 4'h2;
         3'h3: digit_led = 4'h4;
         default: digit_led = 4'h8;
      endcase
   endfunction

   vli_tmr_if #(.W(32)) tmr ();
   vli_step_timer #(.W(32)) u_tmr (
      .pclk(pclk),
      .presetn(presetn),
      .t(tmr)
   );

   // status levels arrive from other cores, so they are synchronised
   logic [3:0] sy1_q; // first stage, read only by the second
   logic [3:0] sy2_q; // usable levels: sdi, done, loading, present
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sy1_q <= 4'h0;
         sy2_q <= 4'h0;
      end else begin
         sy1_q <= {sdi_valid, usb_load_done, usb_loading, usb_present};
         sy2_q <= sy1_q;
      end
   end

   // flash clock and data stretch; the strobe is a same-clock pulse
   logic [31:0] fl_q, fl_d; // flash half-period counter
   logic blink_q, blink_d; // flash phase
   logic [31:0] hold_q, hold_d; // keeps a short receive burst visible
   always_comb begin
      fl_d = fl_q + 32'h1;
      blink_d = blink_q;
      if (fl_q >= 32'(FLASH_CYC - 1)) begin
         fl_d = 32'h0;
         blink_d = ~blink_q;
      end
      hold_d = (hold_q != 32'h0) ? hold_q - 32'h1 : 32'h0;
      if (remote_rx_strobe) begin
         hold_d = 32'(HOLD_CYC); // [R9]
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fl_q <= 32'h0;
         blink_q <= 1'b0;
         hold_q <= 32'h0;
      end else begin
         fl_q <= fl_d;
         blink_q <= blink_d;
         hold_q <= hold_d;
      end
   end

   // apb slave: zero wait states, pready rises in every access phase
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;
   logic skip_q, skip_d; // jump straight to normal indication
   logic allon_q, allon_d; // force every led on
   logic restart_q, restart_d; // one-cycle request to rerun the sequence
   vli_state_t state_q, state_d;
   logic [1:0] step_q, step_d; // lamp test position
   vli_led_t led_q, led_d;
   logic hit;
   always_comb begin
      prdata_d = prdata_q;
      pslverr_d = 1'b0;
      pready_d = psel & ~penable;
      skip_d = skip_q;
      allon_d = allon_q;
      restart_d = 1'b0;
      hit = (paddr == `VLI_OFS_CTRL) || (paddr == `VLI_OFS_STATUS) ||
            (paddr == `VLI_OFS_VERSION);
      if (psel && !penable) begin
         pslverr_d = ~hit; // unmapped: error, reads zero
         prdata_d = 32'h0;
         if (!pwrite) begin
            case (paddr)
               `VLI_OFS_CTRL: begin
                  prdata_d[`VLI_CTRL_SKIP] = skip_q;
                  prdata_d[`VLI_CTRL_ALLON] = allon_q;
               end
               `VLI_OFS_STATUS: begin
                  prdata_d[`VLI_STAT_LED_LSB +: 4] = led_q;
                  prdata_d[`VLI_STAT_PHASE_LSB +: 4] = state_q;
                  prdata_d[`VLI_STAT_DONE] = (state_q == S_NORMAL);
               end
               `VLI_OFS_VERSION: begin
                  prdata_d = {20'h0, mcu_major, mcu_minor, fpga_major, fpga_minor};
               end
               default: prdata_d = 32'h0;
            endcase
         end
      end
      // writes land at the access edge that completes the transfer
      if (psel && penable && pready_q && pwrite && paddr == `VLI_OFS_CTRL) begin
         skip_d = pwdata[`VLI_CTRL_SKIP];
         allon_d = pwdata[`VLI_CTRL_ALLON];
         restart_d = pwdata[`VLI_CTRL_RESTART];
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         skip_q <= 1'(`VLI_CTRL_RST >> `VLI_CTRL_SKIP);
         allon_q <= 1'(`VLI_CTRL_RST >> `VLI_CTRL_ALLON);
         restart_q <= 1'b0;
      end else begin
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         skip_q <= skip_d;
         allon_q <= allon_d;
         restart_q <= restart_d;
      end
   end

   // power-up sequencer; each lamp test step, pause, digit and gap lasts one timer interval
   always_comb begin
      state_d = state_q;
      step_d = step_q;
      tmr.load = 1'b0;
      tmr.cycles = 32'(STEP_CYC);
      case (state_q)
         S_START: begin
            tmr.load = 1'b1; // [R1]
            step_d = 2'h0;
            state_d = S_TEST;
         end
         S_TEST: if (tmr.done) begin
            tmr.load = 1'b1;
            if (step_q == 2'h3) begin
               tmr.cycles = 32'(PAUSE_CYC); // [R3]
               state_d = S_PAUSE1;
            end else begin
               step_d = step_q + 2'h1; // [R1]
            end
         end
         S_PAUSE1, S_GAP1, S_PAUSE2, S_GAP2: if (tmr.done) begin
            tmr.load = 1'b1;
            tmr.cycles = 32'(DIGIT_CYC);
            state_d = vli_state_t'(state_q + 4'h1);
         end
         S_MCU_MAJ, S_FPGA_MAJ: if (tmr.done) begin
            tmr.load = 1'b1;
            tmr.cycles = 32'(GAP_CYC); // [R5]
            state_d = vli_state_t'(state_q + 4'h1);
         end
         S_MCU_MIN, S_FPGA_MIN: if (tmr.done) begin
            tmr.load = 1'b1;
            tmr.cycles = 32'(PAUSE_CYC); // [R4]
            state_d = vli_state_t'(state_q + 4'h1);
         end
         S_PAUSE3: if (tmr.done) begin
            state_d = S_NORMAL; // [R6]
         end
         S_NORMAL: state_d = S_NORMAL;
         default: state_d = S_START;
      endcase
      // skip gives up the display; a restart wins over a skip for one S_START cycle, then skip sends it to S_NORMAL
      if (skip_q && state_q != S_NORMAL) begin
         state_d = S_NORMAL;
      end
      if (restart_q) begin
         state_d = S_START;
      end
   end

   // leds follow the next phase so the outputs line up with state_q
   always_comb begin
      case (state_d)
         S_TEST: led_d = vli_led_t'(4'h1 << step_d); // [R1]
         S_MCU_MAJ: led_d = digit_led(mcu_major); // [R3]
         S_MCU_MIN: led_d = digit_led(mcu_minor); // [R3]
         S_FPGA_MAJ: led_d = digit_led(fpga_major); // [R4]
         S_FPGA_MIN: led_d = digit_led(fpga_minor); // [R4]
         S_NORMAL: begin
            led_d = 4'h0;
            led_d[`VLI_LED_PWR] = 1'b1; // [R6]
            // active only with a drive present: flashing while loading, steady once the load is done
            led_d[`VLI_LED_USB] = sy2_q[0] & ((sy2_q[1] & blink_q) | sy2_q[2]); // [R7] [R10]
            led_d[`VLI_LED_SDI] = sy2_q[3]; // [R8]
            led_d[`VLI_LED_DATA] = remote_rx_strobe | (hold_q != 32'h0); // [R9]
         end
         default: led_d = 4'h0; // pauses and gaps stay dark [R5]
      endcase
      if (allon_q) begin
         led_d = 4'hf;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= S_START;
         step_q <= 2'h0;
         led_q <= 4'h0;
      end else begin
         state_q <= state_d;
         step_q <= step_d;
         led_q <= led_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign led_usb = led_q[`VLI_LED_USB];
   assign led_sdi = led_q[`VLI_LED_SDI];
   assign led_power = led_q[`VLI_LED_PWR];
   assign led_data = led_q[`VLI_LED_DATA];
endmodule // vli_top
`default_nettype wire

// ### tb/vli_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// watches the led sequencer and its apb slave from the top ports
module vli_chk #(
   parameter int STEP_CYC = 4,
   parameter int DIGIT_CYC = 6
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic usb_present,
   input wire logic usb_load_done,
   input wire logic sdi_valid,
   input wire logic remote_rx_strobe,
   input wire logic led_usb,
   input wire logic led_sdi,
   input wire logic led_power,
   input wire logic led_data
);
   logic [7:0] pw_cnt_q; // cycles the power led has been lit in a row
   logic [7:0] pw_cnt_d;
   logic normal; // power lit longer than any test step or digit
   // saturating run counter, so a long normal phase never wraps back
   always_comb begin
      pw_cnt_d = led_power ? pw_cnt_q + {7'h0, pw_cnt_q != 8'hff} : 8'h00;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) pw_cnt_q <= 8'h00;
      else pw_cnt_q <= pw_cnt_d;
   end
   // all-on hides the normal picture, so its span is masked, one led-register cycle late too
   logic allon_m_q, allon_m_d; // mirror of the all-on control bit
   logic allon_lag_q; // mirror delayed by the led register
   always_comb begin
      allon_m_d = allon_m_q;
      if (psel && penable && pready && pwrite && paddr == 8'h00) begin
         allon_m_d = pwdata[2];
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         allon_m_q <= 1'b0;
         allon_lag_q <= 1'b0;
      end else begin
         allon_m_q <= allon_m_d;
         allon_lag_q <= allon_m_q;
      end
   end
   assign normal = led_power && !allon_m_q && !allon_lag_q &&
                   (int'(pw_cnt_q) > STEP_CYC + DIGIT_CYC);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // status level inputs pass a two-flop synchroniser and the led register first; the strobe passes the led register only
   sequence sdi_high;
      sdi_valid[*5];
   endsequence
   sequence usb_gone;
      (!usb_present)[*5];
   endsequence
   sequence usb_loaded;
      (usb_present && usb_load_done)[*5];
   endsequence
   ready_setup_a: assert property (psel && !penable |=> pready)
      else $error("no ready in access cycle");
   err_unmapped_a: assert property (psel && !penable && paddr > 8'h08 |=> pslverr)
      else $error("unmapped access without error");
   all_on_a: assert property (allon_m_q |=> led_usb && led_sdi && led_power && led_data)
      else $error("all-on control not applied");
   single_led_a: assert property ($countones({led_usb, led_sdi, led_power, led_data}) > 1 |-> led_power)
      else $error("several leds lit outside normal");
   power_hold_a: assert property (normal && !psel && !$past(psel) |=> led_power)
      else $error("power led dropped in normal");
   sdi_on_a: assert property (sdi_high ##0 normal |-> led_sdi)
      else $error("video led dark with valid video");
   usb_idle_a: assert property (usb_gone ##0 normal |-> !led_usb)
      else $error("usb led lit without drive");
   usb_steady_a: assert property (usb_loaded ##0 normal |-> led_usb)
      else $error("usb led not steady after load");
   data_on_a: assert property (normal && remote_rx_strobe |=> led_data)
      else $error("data led dark after reception");
   data_off_a: assert property ((!remote_rx_strobe)[*8] ##0 normal |-> !led_data)
      else $error("data led lit without reception");
endmodule // vli_chk
bind vli_top vli_chk #(.STEP_CYC(STEP_CYC), .DIGIT_CYC(DIGIT_CYC)) u_chk (.*);
`default_nettype wire

// ### tb/vli_panel.sv
`timescale 1ns/1ps
`default_nettype none
// operator view of the front panel: logs every change of the lit pattern
module vli_panel (
   input wire logic pclk,
   input wire logic [3:0] leds
);
   logic [3:0] last_q = 4'h0; // pattern noticed last
   logic [3:0] seen[$]; // each new pattern, oldest first
   // an eye sees changes only, so a repeated digit shows through its dark gap
   always @(posedge pclk) begin
      if (leds !== last_q) begin
         seen.push_back(leds);
         last_q = leds;
      end
   end
endmodule // vli_panel
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   typedef struct {logic [11:0] dig; logic [55:0] seq;} vli_row_t;
   logic pclk = 1'h0;
   logic presetn = 1'h0;
   logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err;
   logic [2:0] mcu_major = 3'h1, mcu_minor = 3'h1, fpga_major = 3'h1, fpga_minor = 3'h1;
   logic usb_present = 1'h0, usb_loading = 1'h0, usb_load_done = 1'h0;
   logic sdi_valid = 1'h0, remote_rx_strobe = 1'h0;
   logic led_usb, led_sdi, led_power, led_data;
   logic [3:0] leds; // front panel as one word: data, power, video, usb
   assign leds = {led_data, led_power, led_sdi, led_usb};
   int num_errors = 0;
   int checks = 0;
   int n;
   // digits beside the patterns an operator should see from restart to normal
   vli_row_t rows[3] = '{'{12'h29c, 56'h12480102040804},
      '{12'h8d1, 56'h12480804020104}, '{12'h492, 56'h12480202020204}};
   always #2 pclk = ~pclk;
   vli_top #(.STEP_CYC(4), .DIGIT_CYC(6), .GAP_CYC(3), .PAUSE_CYC(8), .FLASH_CYC(2),
      .HOLD_CYC(5)) uut (.*);
   vli_panel panel (.pclk(pclk), .leds(leds));
   // an unknown result counts as a mismatch
   task chk(input logic ok, input string m);
      checks++;
      if (ok !== 1'h1) begin
         num_errors++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   // one apb transfer, held until pready is seen at a rising edge; only the watchdog ends a wait
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d,
      output logic e);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'h1);
      d = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task give_verdict;
      if (num_errors == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // whole run is under a thousand cycles
   initial begin
      repeat (3000) @(posedge pclk);
      num_errors++;
      give_verdict;
   end
   initial begin
      repeat (3) @(posedge pclk);
      chk(leds === 4'h0 && pready === 1'h0, "outputs not cleared in reset");
      presetn <= 1'h1;
      foreach (rows[i]) begin
         {mcu_major, mcu_minor, fpga_major, fpga_minor} <= rows[i].dig;
         apb(1'h1, 8'h00, 32'h1, rd, err);
         repeat (2) @(posedge pclk);
         #1 panel.seen.delete();
         repeat (90) @(posedge pclk);
         chk(panel.seen.size() == 14, "wrong number of patterns");
         foreach (panel.seen[j]) chk(panel.seen[j] === rows[i].seq[55-4*j -: 4], "pattern");
      end
      // normal indication
      @(posedge pclk);
      sdi_valid <= 1'h1;
      repeat (5) @(posedge pclk);
      chk(led_sdi === 1'h1 && led_power === 1'h1, "video led dark");
      sdi_valid <= 1'h0;
      remote_rx_strobe <= 1'h1;
      @(posedge pclk);
      remote_rx_strobe <= 1'h0;
      #1 chk(led_data === 1'h1, "data led dark");
      repeat (10) @(posedge pclk);
      chk(leds === 4'h4, "only power expected");
      usb_present <= 1'h1;
      usb_loading <= 1'h1;
      n = 0;
      repeat (20) @(posedge pclk) n += int'(led_usb === 1'h1);
      chk(n > 4 && n < 16, "usb led not flashing");
      usb_load_done <= 1'h1;
      repeat (5) @(posedge pclk);
      n = 0;
      repeat (10) @(posedge pclk) n += int'(led_usb === 1'h1);
      chk(n == 10, "usb led not steady");
      usb_present <= 1'h0;
      repeat (5) @(posedge pclk);
      chk(led_usb === 1'h0, "usb led lit without drive");
      // all-on lights every led over the normal picture
      apb(1'h1, 8'h00, 32'h4, rd, err);
      repeat (2) @(posedge pclk);
      chk(leds === 4'hf && err === 1'h0, "all-on not applied");
      // skip with restart: one dark cycle, then normal without the display
      apb(1'h1, 8'h00, 32'h3, rd, err);
      #1 panel.seen.delete();
      repeat (6) @(posedge pclk);
      chk(panel.seen.size() == 2 && panel.seen[0] === 4'h0 && panel.seen[1] === 4'h4,
         "skip did not go straight to normal");
      apb(1'h0, 8'h00, 32'h0, rd, err);
      chk(rd === 32'h2 && err === 1'h0, "control readback");
      apb(1'h0, 8'h04, 32'h0, rd, err);
      chk(rd === 32'h0000_01b4, "status word");
      apb(1'h0, 8'h08, 32'h0, rd, err);
      chk(rd === {20'h0, mcu_major, mcu_minor, fpga_major, fpga_minor}, "version word");
      apb(1'h0, 8'h0c, 32'h0, rd, err);
      chk(err === 1'h1 && rd === 32'h0, "unmapped read");
      // reset in mid run clears the controls and restarts the lamp test
      @(posedge pclk);
      presetn <= 1'h0;
      repeat (2) @(posedge pclk);
      chk(leds === 4'h0 && pready === 1'h0, "outputs not cleared by reset");
      presetn <= 1'h1;
      repeat (3) @(posedge pclk);
      chk(leds === 4'h1, "lamp test not restarted");
      give_verdict;
   end
endmodule // testbench
`default_nettype wire
